// [inc/ioh_pkg.sv]
// package for the host-side controller that drives the five-port io controller pins
package ioh_pkg;
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned BUS_W = 12;
	// opcode field bits 0..2 (msb first) and device code bits 3..8
	localparam int unsigned OPC_HI = 11;
	localparam int unsigned OPC_LO = 9;
	localparam int unsigned DEV_HI = 8;
	localparam int unsigned DEV_LO = 3;
	localparam logic [2:0] OPC_IOT = 3'h6;
	localparam logic [5:0] DEV_NONE = 6'h00;
	localparam logic [2:0] DEV_INT_HI = 3'h2;
	// bus timing figures in ns
	localparam int unsigned T_ADDR_SETUP_NS = 30;
	localparam int unsigned T_ADDR_HOLD_NS = 70;
	localparam int unsigned T_WRITE_SETUP_NS = 50;
	localparam int unsigned T_WRITE_HOLD_NS = 50;
	localparam int unsigned T_WRITE_PULSE_NS = 100;
	localparam int unsigned T_CLR_TO_PHASE_NS = 100;
	localparam int unsigned T_READ_NS = 100;
	localparam int unsigned SETUP_CYC = (T_ADDR_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned AHOLD_CYC = (T_ADDR_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned WSETUP_CYC = (T_WRITE_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned WHOLD_CYC = (T_WRITE_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned WPULSE_CYC = (T_WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned CLRDLY_CYC = (T_CLR_TO_PHASE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned READ_CYC = (T_READ_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned CNT_W = 8;
	// transfer type codes as seen on the two active-low lines {type1_n, type0_n}
	localparam logic [1:0] XT_TO_DEV = 2'h3;
	localparam logic [1:0] XT_TO_DEV_CLR = 2'h2;
	localparam logic [1:0] XT_OR_IN = 2'h1;
	localparam logic [1:0] XT_LOAD = 2'h0;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_SETUP = 4'h1,
		ST_WSET = 4'h3,
		ST_WRITE = 4'h2,
		ST_WHOLD = 4'h6,
		ST_READ = 4'h7,
		ST_RHOLD = 4'h5,
		ST_DONE = 4'h4,
		ST_CLR = 4'hc,
		ST_CLRH = 4'hd
	} ioh_state_e;

	typedef struct packed {
		logic [BUS_W-1:0] instr;
		logic [BUS_W-1:0] data;
		logic power_on;
	} ioh_cmd_s;

	typedef struct packed {
		logic skip;
		logic [1:0] xfer_n;
		logic [BUS_W-1:0] rdata;
	} ioh_result_s;

	typedef struct packed {
		ioh_state_e st;
		logic [CNT_W-1:0] cnt;
		ioh_cmd_s cmd;
		ioh_result_s res;
		logic phase_n;
		logic write_n;
		logic read_n;
		logic clear_n;
		logic bus_oe;
		logic grant_n;
		logic busy;
		logic done;
		logic bad;
		logic [1:0] irq_sync;
		logic [1:0] chain_sync;
		logic [1:0] skip_sync;
		logic [1:0] t0_sync;
		logic [1:0] t1_sync;
		logic [BUS_W-1:0] bus_s1;
		logic [BUS_W-1:0] bus_s2;
		logic [BUS_W-1:0] bus_word;
	} ioh_state_s;
endpackage : ioh_pkg

// [src/ioh_host_ctrl.sv]
// host-side sequencer that issues io instructions and clears to the io controller pins
`timescale 1ns/1ps
// Functional notes
// R1 - host grants interrupt by driving grant low
// R2 - chain input low means no upstream activity
// R3 - transfer command makes addressed strobe true
// R4 - strobe cleared by set-flag or sense
// R5 - sense can skip or interrupt
// R6 - sense edge/level and polarity programmable
// R7 - enables low, only during io phase
// R8 - chain output low grants downstream
// R9 - port five drives chain output
// R10 - skip pulled low during phase and write
// R11 - two open-drain transfer type lines
// R12 - shared open-drain interrupt request line
// R13 - bus active high, bit0 msb
// R14 - host holds phase low during execute/reset
// R15 - host pulses clear at reset and clear-all
// R16 - external io: opcode 6, device not 00/2X
// R17 - up to eleven controllers chained
// R18 - enables decoded from programmed addresses
// R19 - five ports, no data latches inside
// R20 - transfer type encoding of two lines
// R21 - instruction latched at phase falling edge
// R22 - host samples type/skip in phase and write
// R23 - power-on clear: phase low at clear end
module ioh_host_ctrl
	import ioh_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire ioh_cmd_s cmd_in,
	input wire logic cmd_valid_in,
	input wire logic clear_valid_in,
	input wire logic clear_power_on_in,
	input wire logic grant_req_in,
	output logic cmd_ready_out,
	output logic done_out,
	output logic bad_instr_out,
	output ioh_result_s result_out,
	output logic irq_pending_out,
	output logic chain_idle_out,
	output logic [BUS_W-1:0] host_bus_out,
	output logic host_bus_oe_out,
	input wire logic [BUS_W-1:0] host_bus_in,
	output logic io_phase_n_out,
	output logic write_n_out,
	output logic read_n_out,
	output logic host_clear_n_out,
	output logic interrupt_grant_n_out,
	input wire logic skip_n_in,
	input wire logic xfer_type0_n_in,
	input wire logic xfer_type1_n_in,
	input wire logic irq_out_n_in,
	input wire logic chain_enable_out_n_in
);
	ioh_state_s q_r;
	ioh_state_s q_nxt;

	// external io test on the instruction word, bit 0 being the msb
	function automatic logic is_ext(input logic [BUS_W-1:0] w);
		logic [5:0] dev;
		dev = w[DEV_HI:DEV_LO];
		is_ext = (w[OPC_HI:OPC_LO] == OPC_IOT) && (dev != DEV_NONE) && (dev[5:3] != DEV_INT_HI); // see R16 see R13
	endfunction : is_ext

	// next state: one sequence at a time, counter paces every bus phase except the one-cycle read hold and done steps
	always_comb
	begin
		q_nxt = q_r;
		q_nxt.done = 1'b0;
		q_nxt.irq_sync = {q_r.irq_sync[0], ~irq_out_n_in}; // see R12
		q_nxt.chain_sync = {q_r.chain_sync[0], ~chain_enable_out_n_in}; // see R8 see R17
		q_nxt.skip_sync = {q_r.skip_sync[0], skip_n_in};
		q_nxt.t0_sync = {q_r.t0_sync[0], xfer_type0_n_in};
		q_nxt.t1_sync = {q_r.t1_sync[0], xfer_type1_n_in};
		q_nxt.bus_s1 = host_bus_in;
		q_nxt.bus_s2 = q_r.bus_s1;
		q_nxt.grant_n = ~grant_req_in; // see R1
		if (q_r.cnt != '0)
			q_nxt.cnt = q_r.cnt - 1'b1;
		unique case (q_r.st)
			ST_IDLE:
			begin
				q_nxt.busy = 1'b0;
				if (clear_valid_in)
				begin
					// power-on clear keeps phase low past the end of clear
					q_nxt.cmd.power_on = clear_power_on_in;
					q_nxt.phase_n = ~clear_power_on_in; // see R14 see R23
					q_nxt.clear_n = 1'b0; // see R15
					// a clear is never a refused instruction, drop any stale flag
					q_nxt.bad = 1'b0;
					q_nxt.cnt = CNT_W'(WPULSE_CYC);
					q_nxt.busy = 1'b1;
					q_nxt.st = ST_CLR;
				end
				else if (cmd_valid_in)
				begin
					q_nxt.cmd = cmd_in;
					// instruction word goes out first so the phase edge can latch it
					q_nxt.bus_word = cmd_in.instr; // see R21 see R13
					q_nxt.busy = 1'b1;
					if (!is_ext(cmd_in.instr))
					begin
						// not for the controller: refuse without touching the pins
						q_nxt.bad = 1'b1;
						q_nxt.done = 1'b1;
					end
					else
					begin
						q_nxt.bad = 1'b0;
						q_nxt.bus_oe = 1'b1;
						q_nxt.cnt = CNT_W'(SETUP_CYC);
						q_nxt.st = ST_SETUP;
					end
				end
			end
			ST_SETUP:
				if (q_r.cnt == '0)
				begin
					// falling phase edge latches the instruction in the device
					q_nxt.phase_n = 1'b0; // see R21 see R14
					// address hold and write setup run back to back, not overlapped
					q_nxt.cnt = CNT_W'(AHOLD_CYC + WSETUP_CYC);
					q_nxt.st = ST_WSET;
				end
			ST_WSET:
				if (q_r.cnt == '0)
				begin
					q_nxt.write_n = 1'b0;
					q_nxt.cnt = CNT_W'(WPULSE_CYC);
					q_nxt.st = ST_WRITE;
				end
				else if (q_r.cnt == CNT_W'(WSETUP_CYC))
					q_nxt.bus_word = q_r.cmd.data; // see R21
			ST_WRITE:
				if (q_r.cnt == '0)
				begin
					// sample skip and type lines late in write, after sync delay
					q_nxt.res.skip = ~q_r.skip_sync[1]; // see R10 see R22
					q_nxt.res.xfer_n = {q_r.t1_sync[1], q_r.t0_sync[1]}; // see R11 see R20
					q_nxt.write_n = 1'b1;
					q_nxt.cnt = CNT_W'(WHOLD_CYC);
					q_nxt.st = ST_WHOLD;
				end
			ST_WHOLD:
				if (q_r.cnt == '0)
				begin
					if (q_r.res.xfer_n[1] == 1'b0)
					begin
						// device drives bus for input transfers
						q_nxt.bus_oe = 1'b0;
						q_nxt.read_n = 1'b0;
						q_nxt.cnt = CNT_W'(READ_CYC + 2);
						q_nxt.st = ST_READ;
					end
					else
					begin
						q_nxt.st = ST_DONE;
					end
				end
			ST_READ:
				if (q_r.cnt == '0)
				begin
					q_nxt.res.rdata = (q_r.res.xfer_n[0] == 1'b0) ? q_r.bus_s2 : (q_r.cmd.data | q_r.bus_s2); // see R20
					q_nxt.read_n = 1'b1;
					q_nxt.st = ST_RHOLD;
				end
			ST_RHOLD:
				q_nxt.st = ST_DONE;
			ST_DONE:
			begin
				if (q_r.res.xfer_n == XT_TO_DEV_CLR)
					q_nxt.res.rdata = '0; // see R20
				else if (q_r.res.xfer_n == XT_TO_DEV)
					q_nxt.res.rdata = q_r.cmd.data;
				q_nxt.phase_n = 1'b1;
				q_nxt.bus_oe = 1'b0;
				q_nxt.done = 1'b1;
				q_nxt.st = ST_IDLE;
			end
			ST_CLR:
				if (q_r.cnt == '0)
				begin
					q_nxt.clear_n = 1'b1;
					q_nxt.cnt = CNT_W'(CLRDLY_CYC);
					q_nxt.st = ST_CLRH;
				end
			ST_CLRH:
				if (q_r.cnt == '0)
				begin
					q_nxt.phase_n = 1'b1; // see R23
					q_nxt.done = 1'b1;
					q_nxt.st = ST_IDLE;
				end
			default:
				q_nxt.st = ST_IDLE;
		endcase
	end

	// state register, idle pins inactive after reset
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			q_r <= '0;
			q_r.st <= ST_IDLE;
			q_r.phase_n <= 1'b1;
			q_r.write_n <= 1'b1;
			q_r.read_n <= 1'b1;
			q_r.clear_n <= 1'b1;
			q_r.grant_n <= 1'b1;
			q_r.res.xfer_n <= 2'h3;
			q_r.skip_sync <= 2'h3;
			q_r.t0_sync <= 2'h3;
			q_r.t1_sync <= 2'h3;
		end
		else
			q_r <= q_nxt;
	end

	// pin and user outputs straight from flops, except cmd_ready_out which is decoded from the state
	assign cmd_ready_out = (q_r.st == ST_IDLE);
	assign done_out = q_r.done;
	assign bad_instr_out = q_r.bad;
	assign result_out = q_r.res;
	assign irq_pending_out = q_r.irq_sync[1];
	assign chain_idle_out = q_r.chain_sync[1];
	assign host_bus_out = q_r.bus_word;
	assign host_bus_oe_out = q_r.bus_oe;
	assign io_phase_n_out = q_r.phase_n;
	assign write_n_out = q_r.write_n;
	assign read_n_out = q_r.read_n;
	assign host_clear_n_out = q_r.clear_n;
	assign interrupt_grant_n_out = q_r.grant_n;
endmodule : ioh_host_ctrl

// [testbench/ioh_host_ctrl_chk.sv]
// assertions on the host controller pins
`timescale 1ns/1ps
module ioh_chk
	import ioh_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic grant_req_in,
	input wire logic host_bus_oe_out,
	input wire logic io_phase_n_out,
	input wire logic write_n_out,
	input wire logic read_n_out,
	input wire logic host_clear_n_out,
	input wire logic interrupt_grant_n_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);
	chk_grant_next: assert property (grant_req_in |=> !interrupt_grant_n_out) else $error("grant late");
	chk_write_phase: assert property (!write_n_out |-> !io_phase_n_out && host_bus_oe_out)
		else $error("write outside phase");
	chk_read_phase: assert property (!read_n_out |-> !io_phase_n_out && !host_bus_oe_out && write_n_out)
		else $error("read while driving");
	chk_clear_hold: assert property ($fell(host_clear_n_out) |-> !host_clear_n_out [*8])
		else $error("clear too short");
	chk_word_driven: assert property ($fell(io_phase_n_out) && host_clear_n_out |-> host_bus_oe_out)
		else $error("bus idle at phase");
	cover property (!write_n_out);
	cover property (!read_n_out);
	cover property (!host_clear_n_out && !io_phase_n_out);
endmodule : ioh_chk
bind ioh_host_ctrl ioh_chk u_chk (.sys_clk_in, .nrst_in, .grant_req_in, .host_bus_oe_out, .io_phase_n_out,
	.write_n_out, .read_n_out, .host_clear_n_out, .interrupt_grant_n_out);

// [testbench/ioh_dev_model.sv]
// behavioural io controller answering the host pins
`timescale 1ns/1ps
module ioh_dev_model
	import ioh_pkg::*;
#(
	parameter logic [5:0] DEV_ADDR = 6'h05,
	parameter logic [11:0] RD_VAL = 12'h0f0
)
(
	input wire logic [BUS_W-1:0] bus_in,
	input wire logic ph_n_in,
	input wire logic wr_n_in,
	input wire logic rd_n_in,
	input wire logic [1:0] xt_in,
	input wire logic irq_req_in,
	output logic skip_n_out,
	output logic [1:0] xt_n_out,
	output logic irq_n_out,
	output logic chain_n_out,
	output logic [BUS_W-1:0] bus_out
);
	logic [BUS_W-1:0] instr_r = '0;
	logic prog_r = 0;
	logic ext;
	logic hit;
	// command word taken as the phase falls
	always @(negedge ph_n_in) instr_r = bus_in;
	// first io programs the part, then the chain passes on
	always @(posedge ph_n_in) prog_r = prog_r | ext;
	assign ext = instr_r[11:9] == OPC_IOT && instr_r[8:3] != DEV_NONE && instr_r[8:6] != DEV_INT_HI;
	// address match stands in for the programmed chip-select, true only in phase
	assign hit = ext && instr_r[8:3] == DEV_ADDR && !ph_n_in;
	// open-drain lines float high through their pull-ups
	// level sense, true polarity fixed here; the other modes are not modelled
	assign skip_n_out = !(hit && !wr_n_in && xt_in[0]);
	assign xt_n_out = hit ? xt_in : 2'h3;
	assign irq_n_out = !irq_req_in;
	assign chain_n_out = !prog_r;
	// released bus shows the inverse so a stale value never passes
	// read value stands for the port's own input driver, outside the controller
	assign bus_out = (hit && !rd_n_in) ? RD_VAL : ~RD_VAL;
endmodule : ioh_dev_model

// [testbench/ioh_host_ctrl_tb_top.sv]
// self-checking bench for the host controller against the io device model
`timescale 1ns/1ps
module ioh_host_ctrl_tb_top
	import ioh_pkg::*;
;
	logic sys_clk_in = 0;
	logic nrst_in = 0;
	logic cmd_valid_in = 0;
	logic clear_valid_in = 0;
	logic clear_power_on_in = 0;
	logic grant_req_in = 0;
	logic irq_req = 0;
	logic [1:0] xt = 2'h3;
	ioh_cmd_s cmd_in = '0;
	ioh_result_s result_out;
	logic cmd_ready_out, done_out, bad_instr_out, irq_pending_out, chain_idle_out, host_bus_oe_out;
	logic io_phase_n_out, write_n_out, read_n_out, host_clear_n_out, interrupt_grant_n_out;
	logic skip_n, irq_n, ch_n;
	logic [1:0] xn;
	logic [BUS_W-1:0] host_bus_out, host_bus_in, dev_bus;
	logic [BUS_W-1:0] exp_rd [4] = '{12'h0f0, 12'h5f3, 12'h000, 12'h5a3};
	logic [BUS_W-1:0] refused [3] = '{12'hc01, 12'hc98, 12'ha28};
	int fails = 0;
	int checked = 0;
	// host owns the bus only while its enable is up
	assign host_bus_in = host_bus_oe_out ? host_bus_out : dev_bus;
	always #4 sys_clk_in = ~sys_clk_in;
	ioh_host_ctrl DUT (.sys_clk_in, .nrst_in, .cmd_in, .cmd_valid_in, .clear_valid_in, .clear_power_on_in,
		.grant_req_in, .cmd_ready_out, .done_out, .bad_instr_out, .result_out, .irq_pending_out, .chain_idle_out,
		.host_bus_out, .host_bus_oe_out, .host_bus_in, .io_phase_n_out, .write_n_out, .read_n_out,
		.host_clear_n_out, .interrupt_grant_n_out, .skip_n_in(skip_n), .xfer_type0_n_in(xn[0]),
		.xfer_type1_n_in(xn[1]), .irq_out_n_in(irq_n), .chain_enable_out_n_in(ch_n));
	ioh_dev_model u_dev (.bus_in(host_bus_in), .ph_n_in(io_phase_n_out), .wr_n_in(write_n_out),
		.rd_n_in(read_n_out), .xt_in(xt), .irq_req_in(irq_req), .skip_n_out(skip_n), .xt_n_out(xn),
		.irq_n_out(irq_n), .chain_n_out(ch_n), .bus_out(dev_bus));
	task automatic chk(input string what, input logic [BUS_W-1:0] seen, input logic [BUS_W-1:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// one request on the user port, bounded wait for its done pulse
	task automatic run(input logic [1:0] clr, input logic [BUS_W-1:0] instr, input logic exp_bad);
		int n;
		n = 0;
		@(posedge sys_clk_in);
		#1;
		cmd_in = '{instr, 12'h5a3, clr[1]};
		clear_valid_in = clr[0];
		clear_power_on_in = clr[1];
		cmd_valid_in = !clr[0];
		@(posedge sys_clk_in);
		#1;
		cmd_valid_in = 0;
		clear_valid_in = 0;
		while (done_out !== 1'b1 && n < 500)
		begin
			@(posedge sys_clk_in);
			#1;
			n++;
		end
		chk("done", 12'(done_out), 12'h001);
		chk("ready", 12'(cmd_ready_out), 12'h001);
		chk("bad", 12'(bad_instr_out), 12'(exp_bad));
	endtask : run
	task automatic close_out();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	// clears, every transfer type, refusals, interrupt and grant
	initial
	begin
		repeat (12) @(posedge sys_clk_in);
		#1;
		nrst_in = 1;
		run(2'h3, 12'h000, 0);
		for (int t = 0; t < 4; t++)
		begin
			xt = 2'(t);
			run(2'h0, 12'hc28, 0);
			chk("xfer", 12'(result_out.xfer_n), 12'(t));
			chk("skip", 12'(result_out.skip), 12'(t[0]));
			chk("rdata", result_out.rdata, exp_rd[t]);
		end
		foreach (refused[i])
			run(2'h0, refused[i], 1);
		chk("chain", 12'(chain_idle_out), 12'h001);
		run(2'h1, 12'h000, 0);
		irq_req = 1;
		repeat (5) @(posedge sys_clk_in);
		#1;
		chk("irq", 12'(irq_pending_out), 12'h001);
		grant_req_in = 1;
		repeat (2) @(posedge sys_clk_in);
		#1;
		chk("grant", 12'(interrupt_grant_n_out), 12'h000);
		close_out();
	end
	// hang guard far beyond the expected few microseconds
	initial
	begin
		#50000;
		fails++;
		close_out();
	end
endmodule : ioh_host_ctrl_tb_top
